// ==== pkg/htsr_crc_if.sv ====
// link between the byte engine and the crc engine
`timescale 1ns/100ps
interface htsr_crc_if;
  logic       init;
  logic       feed;
  logic [7:0] data;
  logic [7:0] crc;

  modport src (output init, output feed, output data, input crc);
  modport eng (input init, input feed, input data, output crc);
endinterface

// ==== pkg/htsr_pkg.sv ====
// constants shared by the humidity and temperature sensor readout block
package htsr_pkg;
  // bus address and command set
  localparam logic [6:0] DEV_ADDR   = 7'h38;
  localparam logic [7:0] CMD_STATUS = 8'h71;
  localparam logic [7:0] CMD_INIT   = 8'hBE;
  localparam logic [7:0] INIT_P1    = 8'h08;
  localparam logic [7:0] INIT_P2    = 8'h00;
  localparam logic [7:0] CMD_MEAS   = 8'hAC;
  localparam logic [7:0] MEAS_P1    = 8'h33;
  localparam logic [7:0] MEAS_P2    = 8'h00;
  localparam logic [7:0] CMD_SOFT   = 8'hBA;

  // status byte layout
  localparam int         STAT_BUSY_BIT = 7;
  localparam int         STAT_CAL_BIT  = 3;

  // result frame layout: status, five data bytes, crc
  localparam int         RAW_W         = 20;
  localparam logic [2:0] IDX_STATUS    = 3'h0;
  localparam logic [2:0] IDX_HUM_HI    = 3'h1;
  localparam logic [2:0] IDX_HUM_MID   = 3'h2;
  localparam logic [2:0] IDX_SHARED    = 3'h3;
  localparam logic [2:0] IDX_TMP_MID   = 3'h4;
  localparam logic [2:0] IDX_TMP_LO    = 3'h5;
  localparam logic [2:0] IDX_CRC       = 3'h6;
  localparam logic [2:0] IDX_LAST      = 3'h7;
  localparam logic [7:0] FILL_BYTE     = 8'hFF;

  // crc over the frame: x^8+x^5+x^4+1, preset all ones
  localparam logic [7:0] CRC_POLY      = 8'h31;
  localparam logic [7:0] CRC_PRESET    = 8'hFF;

  // timing
  localparam int         CLK_KHZ       = 125000;
  localparam int         MEAS_TIME_MS  = 80;
  localparam int         INIT_TIME_MS  = 10;
  localparam int         RESET_TIME_MS = 20;
  localparam int         MEAS_CYCLES   = MEAS_TIME_MS * CLK_KHZ;
  localparam int         INIT_CYCLES   = INIT_TIME_MS * CLK_KHZ;
  localparam int         RESET_CYCLES  = RESET_TIME_MS * CLK_KHZ;
  localparam int         TMR_W         = 24;
endpackage

// ==== sim/htsr_host_model.sv ====
// two-wire bus master standing in for the host controller
`timescale 1ns/100ps
module htsr_host_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      host_oe
);
  // one bus bit is 8 clk (64 ns); both lines move only on falling clk edges
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic bit_io(input logic b, output logic r);
    wt(2);
    host_oe = ~b;
    wt(2);
    scl = 1'h1;
    wt(2);
    r = sda_line;
    wt(2);
    scl = 1'h0;
  endtask

  // data released before the clock rises, so this also serves as repeated start
  task automatic start();
    wt(2);
    host_oe = 1'h0;
    wt(2);
    scl = 1'h1;
    wt(4);
    host_oe = 1'h1;
    wt(4);
    scl = 1'h0;
  endtask

  task automatic stop();
    wt(2);
    host_oe = 1'h1;
    wt(2);
    scl = 1'h1;
    wt(4);
    host_oe = 1'h0;
    wt(4);
  endtask

  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'h1, r);
    ack = ~r;  // low on the ninth clock
  endtask

  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'h1, r);
      d[i] = r;
    end
    bit_io(last, r);  // not acknowledging the last byte ends the read
  endtask

  initial
  begin
    scl     = 1'h1;  // bus clock stands high between frames
    host_oe = 1'h0;
  end
endmodule

// ==== sim/htsr_readout_sva.sv ====
// port-level assertions for the sensor readout block
`timescale 1ns/100ps
module htsr_readout_sva #(
  parameter int unsigned MEAS_CYCLES  = 200,
  parameter int unsigned INIT_CYCLES  = 100,
  parameter int unsigned RESET_CYCLES = 50
) (
  input wire logic                       clk,
  input wire logic                       sys_rst,
  input wire logic                       scl_in,
  input wire logic                       sda_in,
  input wire logic                       sda_out,
  input wire logic                       sda_oe,
  input wire logic [htsr_pkg::RAW_W-1:0] raw_humidity_count,
  input wire logic [htsr_pkg::RAW_W-1:0] raw_temperature_count,
  input wire logic                       cal_stored,
  input wire logic                       busy,
  input wire logic                       calibrated
);
  int unsigned boot_cnt_reg;
  int unsigned busy_len_reg;
  int unsigned quiet_reg;
  logic        scl_last_reg;

  // saturates so a long idle never wraps back into the boot window
  always_ff @(posedge clk)
    boot_cnt_reg <= sys_rst ? 0 : boot_cnt_reg + 32'(boot_cnt_reg < RESET_CYCLES);

  always_ff @(posedge clk)
    busy_len_reg <= (sys_rst || !busy) ? 0 : busy_len_reg + 1;

  always_ff @(posedge clk)
    scl_last_reg <= scl_in;

  // cycles since the bus clock last moved; the slave only acts just after an edge
  always_ff @(posedge clk)
    quiet_reg <= (scl_in != scl_last_reg) ? 0 : quiet_reg + 32'(quiet_reg < 255);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  rst_quiet_a: assert property ($fell(sys_rst) |-> !sda_oe && !busy && !calibrated)
    else $error("outputs not cleared by reset");
  drain_only_a: assert property (sda_out == 1'h0)
    else $error("data pin driven high");
  boot_no_ack_a: assert property (boot_cnt_reg < RESET_CYCLES |-> !sda_oe)
    else $error("bus driven during start-up");
  boot_idle_a: assert property (boot_cnt_reg < RESET_CYCLES |-> !busy && !calibrated)
    else $error("busy or calibrated during start-up");
  busy_len_a: assert property ($fell(busy) |->
    busy_len_reg == MEAS_CYCLES || busy_len_reg == INIT_CYCLES)
    else $error("busy time differs from conversion or init time");
  busy_hold_a: assert property ($rose(busy) |=> busy [*8])
    else $error("busy dropped right after it rose");
  cal_source_a: assert property ($rose(calibrated) |->
    $past(busy) || $past(busy, 2) || cal_stored)
    else $error("calibrated set without init or stored flag");
  ack_on_clock_a: assert property ($changed(sda_oe) |-> quiet_reg < 6)
    else $error("data pin moved away from a bus clock edge");
endmodule

bind htsr_readout htsr_readout_sva #(
  .MEAS_CYCLES  (MEAS_CYCLES),
  .INIT_CYCLES  (INIT_CYCLES),
  .RESET_CYCLES (RESET_CYCLES)
) u_htsr_readout_sva (
  .clk, .sys_rst, .scl_in, .sda_in, .sda_out, .sda_oe, .raw_humidity_count,
  .raw_temperature_count, .cal_stored, .busy, .calibrated
);

// ==== sim/tb.sv ====
// self-checking bench for the sensor readout block
`timescale 1ns/100ps
module tb;
  localparam int unsigned MEAS_N = 800;
  localparam int unsigned INIT_N = 300;
  localparam int unsigned BOOT_N = 200;

  logic                       clk;
  logic                       sys_rst;
  logic                       cal_stored;
  logic [htsr_pkg::RAW_W-1:0] hum;
  logic [htsr_pkg::RAW_W-1:0] tmp;
  logic                       sda_out;
  logic                       sda_oe;
  logic                       busy;
  logic                       calibrated;
  wire                        scl;
  wire                        host_oe;
  wire                        sda_line;
  int                         fail_count;
  int                         tests_run;
  logic [7:0]                 rb [0:7];

  // open drain with pull-up: a released line reads high
  assign sda_line = ~(host_oe | sda_oe);

  htsr_readout #(.MEAS_CYCLES(MEAS_N), .INIT_CYCLES(INIT_N), .RESET_CYCLES(BOOT_N))
    u_htsr_readout (
    .clk, .sys_rst, .scl_in (scl), .sda_in (sda_line), .sda_out, .sda_oe,
    .raw_humidity_count (hum), .raw_temperature_count (tmp), .cal_stored, .busy, .calibrated);

  htsr_host_model u_htsr_host_model (.clk, .sda_line, .scl, .host_oe);

  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // address byte, then n bytes from seq msb first, then stop
  task automatic cmd(input logic [23:0] seq, input int n, input logic exp_ack);
    logic ack;
    u_htsr_host_model.start();
    u_htsr_host_model.put({htsr_pkg::DEV_ADDR, 1'h0}, ack);
    check(ack, exp_ack);
    for (int i = 0; i < n; i++)
    begin
      u_htsr_host_model.put(seq[23-8*i -: 8], ack);
      check(ack, 1'h1);
    end
    u_htsr_host_model.stop();
  endtask

  task automatic rd(input int n);
    logic ack;
    u_htsr_host_model.start();
    u_htsr_host_model.put({htsr_pkg::DEV_ADDR, 1'h1}, ack);
    check(ack, 1'h1);
    for (int i = 0; i < n; i++)
      u_htsr_host_model.get(i == n - 1, rb[i]);
    u_htsr_host_model.stop();
  endtask

  function automatic logic [7:0] crc8(input logic [7:0] b [0:7]);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 0; i < 6; i++)
    begin
      c ^= b[i];
      for (int k = 0; k < 8; k++)
        c = c[7] ? {c[6:0], 1'h0} ^ 8'h31 : {c[6:0], 1'h0};
    end
    return c;
  endfunction

  task automatic t_frame(input logic [7:0] sb, input logic [19:0] h, input logic [19:0] t);
    logic [7:0] eb [0:7];
    eb = '{sb, h[19:12], h[11:4], {h[3:0], t[19:16]}, t[15:8], t[7:0], 8'h00, 8'hFF};
    eb[6] = crc8(eb);
    rd(8);
    for (int i = 0; i < 8; i++)
      check(rb[i], eb[i]);
  endtask

  task automatic t_boot();
    logic ack;
    cmd(24'h0, 0, 1'h0);
    check({busy, calibrated}, 2'h0);
    idle(BOOT_N);
    u_htsr_host_model.start();
    u_htsr_host_model.put({7'h39, 1'h0}, ack);
    check(ack, 1'h0);
    u_htsr_host_model.stop();
    rd(1);
    check(rb[0], 8'h00);
  endtask

  task automatic t_init();
    cmd({htsr_pkg::CMD_INIT, 8'h09, htsr_pkg::INIT_P2}, 3, 1'h1);
    check(busy, 1'h0);
    cmd({htsr_pkg::CMD_INIT, htsr_pkg::INIT_P1, htsr_pkg::INIT_P2}, 3, 1'h1);
    check(busy, 1'h1);
    rd(1);
    check(rb[0], 8'h80);
    idle(INIT_N);
    rd(1);
    check(rb[0], 8'h08);
    check(calibrated, 1'h1);
  endtask

  task automatic t_meas();
    int n;
    int rh;
    int tc;
    hum = 20'h12345;
    cmd({htsr_pkg::CMD_MEAS, htsr_pkg::MEAS_P1, htsr_pkg::MEAS_P2}, 3, 1'h1);
    // counts change mid-conversion; only the values at its end may appear
    hum = 20'hA5C3E;
    tmp = 20'h5B7D1;
    rd(1);
    check(rb[0], 8'h88);
    cmd({htsr_pkg::CMD_MEAS, htsr_pkg::MEAS_P1, htsr_pkg::MEAS_P2}, 3, 1'h1);
    idle(MEAS_N);
    n = 0;
    do
    begin
      rd(1);
      n++;
    end while (rb[0][7] !== 1'h0 && n < 20);
    if (rb[0][7] !== 1'h0)
    begin
      fail_count++;
      stop_test();
    end
    t_frame(8'h08, hum, tmp);
    // host-side scaling of the frame: 64 %RH and 21 degC for the counts driven above
    rh = ({rb[1], rb[2], rb[3][7:4]} * 100) >> 20;
    tc = (({rb[3][3:0], rb[4], rb[5]} * 200) >> 20) - 50;
    check(24'(rh), 24'h40);
    check(24'(tc), 24'h15);
  endtask

  task automatic t_soft();
    cal_stored = 1'h1;
    cmd({htsr_pkg::CMD_SOFT, 16'h0}, 1, 1'h1);
    check(calibrated, 1'h0);
    cmd(24'h0, 0, 1'h0);
    idle(BOOT_N);
    check(calibrated, 1'h1);
    t_frame(8'h08, 20'h0, 20'h0);
  endtask

  initial
  begin
    sys_rst    = 1'h1;
    cal_stored = 1'h0;
    hum        = '0;
    tmp        = '0;
    fail_count = 0;
    tests_run  = 0;
    repeat (2) @(negedge clk);
    sys_rst = 1'h0;
    t_boot();
    t_init();
    t_meas();
    t_meas();  // routine cycle without the calibration
    t_soft();
    stop_test();
  end
endmodule

// ==== verilog/htsr_crc8.sv ====
// crc engine over the transmitted result bytes
`timescale 1ns/100ps
module htsr_crc8 (
  input wire logic   clk,
  input wire logic   sys_rst,
  htsr_crc_if.eng    crc_port
);

  logic [7:0] crc_reg;

  function automatic logic [7:0] htsr_crc_step(input logic [7:0] seed,
                                               input logic [7:0] data);
    logic [7:0] c;
    c = seed ^ data;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ({c[6:0], 1'b0} ^ htsr_pkg::CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      crc_reg <= htsr_pkg::CRC_PRESET;
    else if (crc_port.feed)
      // msb first, seeded with all ones on the first byte
      crc_reg <= htsr_crc_step(crc_port.init ? htsr_pkg::CRC_PRESET : crc_reg,
                               crc_port.data);
    else if (crc_port.init)
      crc_reg <= htsr_pkg::CRC_PRESET;
  end

  assign crc_port.crc = crc_reg;

endmodule

// ==== verilog/htsr_readout.sv ====
// two-wire bus slave, command decode and conversion control of the sensor
`timescale 1ns/100ps
module htsr_readout #(
  parameter int unsigned MEAS_CYCLES  = htsr_pkg::MEAS_CYCLES,
  parameter int unsigned INIT_CYCLES  = htsr_pkg::INIT_CYCLES,
  parameter int unsigned RESET_CYCLES = htsr_pkg::RESET_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        scl_in,
  input  wire logic                        sda_in,
  output logic                             sda_out,
  output logic                             sda_oe,
  input  wire logic [htsr_pkg::RAW_W-1:0]  raw_humidity_count,
  input  wire logic [htsr_pkg::RAW_W-1:0]  raw_temperature_count,
  input  wire logic                        cal_stored,
  output logic                             busy,
  output logic                             calibrated
);

  typedef logic [htsr_pkg::TMR_W-1:0] htsr_tmr_t;

  typedef enum logic [4:0] {
    BUS_IDLE = 5'b00001,
    BUS_RX   = 5'b00010,
    BUS_RACK = 5'b00100,
    BUS_TX   = 5'b01000,
    BUS_TACK = 5'b10000
  } htsr_bus_t;

  typedef enum logic [3:0] {
    DEV_BOOT = 4'b0001,
    DEV_IDLE = 4'b0010,
    DEV_MEAS = 4'b0100,
    DEV_INIT = 4'b1000
  } htsr_dev_t;

  logic                        scl_meta_reg;
  logic                        scl_sync_reg;
  logic                        scl_prev_reg;
  logic                        sda_meta_reg;
  logic                        sda_sync_reg;
  logic                        sda_prev_reg;
  logic                        scl_rise;
  logic                        scl_fall;
  logic                        bus_start;
  logic                        bus_stop;

  htsr_bus_t                   bus_state_reg;
  logic [3:0]                  bit_cnt_reg;
  logic [7:0]                  rx_shift_reg;
  logic [7:0]                  tx_shift_reg;
  logic                        addr_phase_reg;
  logic                        is_read_reg;
  logic                        nack_reg;
  logic [1:0]                  wr_cnt_reg;
  logic [7:0]                  cmd_reg;
  logic [7:0]                  param1_reg;
  logic [2:0]                  rd_idx_reg;
  logic                        sda_oe_reg;

  htsr_dev_t                   dev_state_reg;
  htsr_tmr_t                   timer_reg;
  logic                        cal_reg;
  logic [htsr_pkg::RAW_W-1:0]  hum_reg;
  logic [htsr_pkg::RAW_W-1:0]  tmp_reg;

  logic                        byte_done;
  logic                        data_taken;
  logic                        cmd_soft;
  logic                        cmd_meas;
  logic                        cmd_init;
  logic                        load_now;
  logic [7:0]                  status_byte;
  logic [7:0]                  tx_byte;

  htsr_crc_if crc_link ();

  htsr_crc8 u_crc (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .crc_port (crc_link.eng)
  );

  // pins come from the host's domain; only the second and third stages are used downstream
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  assign scl_rise  = scl_sync_reg & ~scl_prev_reg;
  assign scl_fall  = ~scl_sync_reg & scl_prev_reg;
  assign bus_start = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  assign bus_stop  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

  assign byte_done  = (bus_state_reg == BUS_RX) && scl_fall && (bit_cnt_reg == 4'h8);
  assign data_taken = byte_done && !addr_phase_reg;

  // commands act on the falling edge that opens their ack
  assign cmd_soft = data_taken && (wr_cnt_reg == 2'h0)
                    && (rx_shift_reg == htsr_pkg::CMD_SOFT);
  assign cmd_meas = data_taken && (wr_cnt_reg == 2'h2) && (cmd_reg == htsr_pkg::CMD_MEAS)
                    && (param1_reg == htsr_pkg::MEAS_P1)
                    && (rx_shift_reg == htsr_pkg::MEAS_P2);
  assign cmd_init = data_taken && (wr_cnt_reg == 2'h2) && (cmd_reg == htsr_pkg::CMD_INIT)
                    && (param1_reg == htsr_pkg::INIT_P1)
                    && (rx_shift_reg == htsr_pkg::INIT_P2);

  assign load_now = scl_fall && (((bus_state_reg == BUS_RACK) && is_read_reg)
                    || ((bus_state_reg == BUS_TACK) && !nack_reg));

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[htsr_pkg::STAT_BUSY_BIT] = busy;
    status_byte[htsr_pkg::STAT_CAL_BIT]  = cal_reg;
  end

  // every read opens with the status byte, so a 0x71 poll is a one-byte read
  always_comb
  begin
    unique case (rd_idx_reg)
      htsr_pkg::IDX_STATUS:  tx_byte = status_byte;
      htsr_pkg::IDX_HUM_HI:  tx_byte = hum_reg[19:12];
      htsr_pkg::IDX_HUM_MID: tx_byte = hum_reg[11:4];
      htsr_pkg::IDX_SHARED:  tx_byte = {hum_reg[3:0], tmp_reg[19:16]};
      htsr_pkg::IDX_TMP_MID: tx_byte = tmp_reg[15:8];
      htsr_pkg::IDX_TMP_LO:  tx_byte = tmp_reg[7:0];
      htsr_pkg::IDX_CRC:     tx_byte = crc_link.crc;
      htsr_pkg::IDX_LAST:    tx_byte = htsr_pkg::FILL_BYTE;
    endcase
  end

  assign crc_link.init = load_now && (rd_idx_reg == htsr_pkg::IDX_STATUS);
  assign crc_link.feed = load_now && (rd_idx_reg <= htsr_pkg::IDX_TMP_LO);
  assign crc_link.data = tx_byte;

  // bus byte engine
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bus_state_reg  <= BUS_IDLE;
      bit_cnt_reg    <= 4'h0;
      rx_shift_reg   <= 8'h00;
      tx_shift_reg   <= 8'h00;
      addr_phase_reg <= 1'b0;
      is_read_reg    <= 1'b0;
      nack_reg       <= 1'b0;
      wr_cnt_reg     <= 2'h0;
      cmd_reg        <= 8'h00;
      param1_reg     <= 8'h00;
      rd_idx_reg     <= 3'h0;
      sda_oe_reg     <= 1'b0;
    end
    else if (bus_start)
    begin
      bus_state_reg  <= BUS_RX;
      bit_cnt_reg    <= 4'h0;
      addr_phase_reg <= 1'b1;
      sda_oe_reg     <= 1'b0;
    end
    else if (bus_stop)
    begin
      bus_state_reg <= BUS_IDLE;
      sda_oe_reg    <= 1'b0;
    end
    else
    begin
      unique case (bus_state_reg)
        BUS_IDLE:
        begin
          sda_oe_reg <= 1'b0;
        end
        BUS_RX:
        begin
          if (scl_rise)
          begin
            rx_shift_reg <= {rx_shift_reg[6:0], sda_sync_reg};
            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
          end
          else if (byte_done && addr_phase_reg)
          begin
            // no answer while booting after reset
            if ((rx_shift_reg[7:1] == htsr_pkg::DEV_ADDR) && (dev_state_reg != DEV_BOOT))
            begin
              bus_state_reg <= BUS_RACK;
              sda_oe_reg    <= 1'b1;
              is_read_reg   <= rx_shift_reg[0];
              wr_cnt_reg    <= 2'h0;
              rd_idx_reg    <= htsr_pkg::IDX_STATUS;
            end
            else
              bus_state_reg <= BUS_IDLE;
          end
          else if (byte_done)
          begin
            bus_state_reg <= BUS_RACK;
            sda_oe_reg    <= 1'b1;
            if (wr_cnt_reg == 2'h0)
              cmd_reg <= rx_shift_reg;
            if (wr_cnt_reg == 2'h1)
              param1_reg <= rx_shift_reg;
            if (wr_cnt_reg != 2'h3)
              wr_cnt_reg <= wr_cnt_reg + 2'h1;
          end
        end
        BUS_RACK:
        begin
          if (scl_fall)
          begin
            addr_phase_reg <= 1'b0;
            bit_cnt_reg    <= 4'h0;
            if (is_read_reg)
            begin
              bus_state_reg <= BUS_TX;
              tx_shift_reg  <= tx_byte;
              sda_oe_reg    <= ~tx_byte[7];
              if (rd_idx_reg != htsr_pkg::IDX_LAST)
                rd_idx_reg <= rd_idx_reg + 3'h1;
            end
            else
            begin
              bus_state_reg <= BUS_RX;
              sda_oe_reg    <= 1'b0;
            end
          end
        end
        BUS_TX:
        begin
          if (scl_rise)
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          else if (scl_fall && (bit_cnt_reg == 4'h8))
          begin
            bus_state_reg <= BUS_TACK;
            sda_oe_reg    <= 1'b0;
          end
          else if (scl_fall)
          begin
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            sda_oe_reg   <= ~tx_shift_reg[6];
          end
        end
        BUS_TACK:
        begin
          if (scl_rise)
            nack_reg <= sda_sync_reg;
          else if (scl_fall && nack_reg)
            bus_state_reg <= BUS_IDLE;
          else if (load_now)
          begin
            // the host may stop after byte six and skip the crc
            bus_state_reg <= BUS_TX;
            bit_cnt_reg   <= 4'h0;
            tx_shift_reg  <= tx_byte;
            sda_oe_reg    <= ~tx_byte[7];
            if (rd_idx_reg != htsr_pkg::IDX_LAST)
              rd_idx_reg <= rd_idx_reg + 3'h1;
          end
        end
      endcase
    end
  end

  // conversion, initialisation and reset sequencing
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dev_state_reg <= DEV_BOOT;
      timer_reg     <= htsr_tmr_t'(RESET_CYCLES - 1);
      cal_reg       <= 1'b0;
      hum_reg       <= '0;
      tmp_reg       <= '0;
    end
    else if (cmd_soft)
    begin
      // soft reset wins over any sequence in flight
      dev_state_reg <= DEV_BOOT;
      timer_reg     <= htsr_tmr_t'(RESET_CYCLES - 1);
      cal_reg       <= 1'b0;
      hum_reg       <= '0;
      tmp_reg       <= '0;
    end
    else
    begin
      unique case (dev_state_reg)
        DEV_BOOT:
        begin
          if (timer_reg == '0)
          begin
            dev_state_reg <= DEV_IDLE;
            cal_reg       <= cal_stored;
          end
          else
            timer_reg <= timer_reg - htsr_tmr_t'(1);
        end
        DEV_IDLE:
        begin
          if (cmd_meas)
          begin
            dev_state_reg <= DEV_MEAS;
            timer_reg     <= htsr_tmr_t'(MEAS_CYCLES - 1);
          end
          else if (cmd_init)
          begin
            dev_state_reg <= DEV_INIT;
            timer_reg     <= htsr_tmr_t'(INIT_CYCLES - 1);
          end
        end
        DEV_MEAS:
        begin
          // triggers arriving mid conversion are dropped, not queued
          if (timer_reg == '0)
          begin
            dev_state_reg <= DEV_IDLE;
            hum_reg       <= raw_humidity_count;
            tmp_reg       <= raw_temperature_count;
          end
          else
            timer_reg <= timer_reg - htsr_tmr_t'(1);
        end
        DEV_INIT:
        begin
          if (timer_reg == '0)
          begin
            dev_state_reg <= DEV_IDLE;
            cal_reg       <= 1'b1;
          end
          else
            timer_reg <= timer_reg - htsr_tmr_t'(1);
        end
      endcase
    end
  end

  assign busy       = dev_state_reg[2] | dev_state_reg[3];
  assign calibrated = cal_reg;
  assign sda_out    = 1'b0;
  assign sda_oe     = sda_oe_reg;

endmodule
